// ---- pcstack_pkg.sv ----
// Shared constants and types for the program counter, return stack and indirect addressing
package pcstack_pkg;
    // Widths
    localparam int PC_W        = 13;
    localparam int LOW_W       = 8;
    localparam int LATCH_W     = 5;
    localparam int PAGE_W      = 11;
    localparam int STACK_DEPTH = 8;
    localparam int DATA_W      = 8;
    localparam int DADDR_W     = 9;
    localparam int FADDR_W     = 7;
    localparam int IDX_W       = 6;
    localparam int BUS_W       = 32;

    // Field positions
    localparam int PAGE_SEL_HI = 4;
    localparam int PAGE_SEL_LO = 3;
    localparam int BANK_BIT    = 7;
    localparam int IDX_LSB     = 2;
    localparam int IDX_MSB     = 7;
    localparam int TRANS_BIT   = 1;

    // Reset values and fixed codes
    localparam logic [PC_W-1:0]    PC_RESET      = 13'h0000;
    localparam logic [PC_W-1:0]    PC_ONE        = 13'h0001;
    localparam logic [LATCH_W-1:0] LATCH_RESET   = 5'h00;
    localparam logic [DATA_W-1:0]  DATA_ZERO     = 8'h00;
    localparam logic [FADDR_W-1:0] INDIRECT_PORT = 7'h00;
    localparam logic [BUS_W-1:0]   BUS_ZERO      = 32'h0000_0000;
    localparam logic               HRESP_OKAY    = 1'b0;

    // Register word indices, byte address is index times four
    localparam logic [IDX_W-1:0] IDX_PC_LOW   = 6'h00;
    localparam logic [IDX_W-1:0] IDX_PC_LATCH = 6'h01;
    localparam logic [IDX_W-1:0] IDX_FSR      = 6'h02;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h03;

    // Program counter source, highest priority last
    typedef enum logic [2:0] {
        FLOW_HOLD   = 3'b000,
        FLOW_STEP   = 3'b001,
        FLOW_PCL    = 3'b010,
        FLOW_JUMP   = 3'b011,
        FLOW_CALL   = 3'b100,
        FLOW_RET    = 3'b101,
        FLOW_VECTOR = 3'b110
    } flow_t;

    function automatic logic [IDX_W-1:0] reg_index(input logic [BUS_W-1:0] addr);
        return addr[IDX_MSB:IDX_LSB];
    endfunction : reg_index
endpackage : pcstack_pkg

// ---- return_stack_mem.sv ----
// Circular return stack memory with a registered top-of-stack output
`timescale 1ns/1ps
module return_stack_mem #(
    parameter int DEPTH = pcstack_pkg::STACK_DEPTH,
    parameter int WIDTH = pcstack_pkg::PC_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Stack operations
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] top_r
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
    localparam logic [PTR_W-1:0] PTR_TWO = PTR_W'(2);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] ptr_r;

    // Pointer wraps silently; no overflow or underflow flag exists
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_r <= '0;
        end else if (pop) begin
            ptr_r <= ptr_r - PTR_ONE;
        end else if (push) begin
            ptr_r <= ptr_r + PTR_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !pop) begin
            mem[ptr_r] <= wdata;
        end
    end

    // Top is kept in a register so a pop needs no read latency
    always_ff @(posedge clk) begin
        if (reset) begin
            top_r <= '0;
        end else if (pop) begin
            top_r <= mem[ptr_r - PTR_TWO];
        end else if (push) begin
            top_r <= wdata;
        end
    end

    property p_ptr_wrap;
        @(posedge clk) disable iff (reset)
        (push && !pop) |=> (ptr_r == $past(ptr_r) + PTR_ONE);
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("stack pointer did not advance");

    property p_pop_back;
        @(posedge clk) disable iff (reset)
        (push && !pop) ##1 (pop && !push) |-> (top_r == $past(wdata));
    endproperty
    a_pop_back: assert property (p_pop_back) else $error("push then pop lost value");
endmodule : return_stack_mem

// ---- indirect_addr_unit.sv ----
// Indirect file-register address former with null-port handling
`timescale 1ns/1ps
module indirect_addr_unit (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            reset,
    // Pointer state
    input  wire logic [pcstack_pkg::DATA_W-1:0]  file_select_pointer,
    input  wire logic                            bank,
    // Decoder file access
    input  wire logic [pcstack_pkg::DADDR_W-1:0] file_addr,
    input  wire logic                            file_rd,
    input  wire logic                            file_wr,
    input  wire logic [pcstack_pkg::DATA_W-1:0]  file_wdata,
    output logic      [pcstack_pkg::DATA_W-1:0]  file_rdata_r,
    output logic                                 file_rvalid_r,
    // Data memory side
    output logic      [pcstack_pkg::DADDR_W-1:0] mem_addr_r,
    output logic                                 mem_rd_r,
    output logic                                 mem_wr_r,
    output logic      [pcstack_pkg::DATA_W-1:0]  mem_wdata_r,
    input  wire logic [pcstack_pkg::DATA_W-1:0]  mem_rdata
);
    logic                            is_ind;
    logic                            self_ref;
    logic                            blocked;
    logic                            null_rd_r;
    logic [pcstack_pkg::DADDR_W-1:0] eff_addr;

    assign is_ind   = file_addr[pcstack_pkg::FADDR_W-1:0] == pcstack_pkg::INDIRECT_PORT;
    assign self_ref = file_select_pointer[pcstack_pkg::FADDR_W-1:0] == pcstack_pkg::INDIRECT_PORT;
    assign blocked  = is_ind && self_ref;
    assign eff_addr = is_ind ? {bank, file_select_pointer} : file_addr;

    always_ff @(posedge clk) begin
        if (reset) begin
            mem_addr_r  <= '0;
            mem_rd_r    <= 1'b0;
            mem_wr_r    <= 1'b0;
            mem_wdata_r <= pcstack_pkg::DATA_ZERO;
            null_rd_r   <= 1'b0;
        end else begin
            mem_addr_r  <= eff_addr;
            mem_rd_r    <= file_rd && !blocked;
            mem_wr_r    <= file_wr && !blocked;
            mem_wdata_r <= file_wdata;
            null_rd_r   <= file_rd && blocked;
        end
    end

    // Returned one cycle after the memory strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            file_rdata_r  <= pcstack_pkg::DATA_ZERO;
            file_rvalid_r <= 1'b0;
        end else begin
            file_rvalid_r <= mem_rd_r || null_rd_r;
            if (null_rd_r) begin
                file_rdata_r <= pcstack_pkg::DATA_ZERO;
            end else if (mem_rd_r) begin
                file_rdata_r <= mem_rdata;
            end
        end
    end

    property p_null_read;
        @(posedge clk) disable iff (reset)
        (file_rd && blocked) |=> !mem_rd_r ##1 (file_rvalid_r && file_rdata_r == 8'h00);
    endproperty
    a_null_read: assert property (p_null_read) else $error("null read not zero");

    property p_null_write;
        @(posedge clk) disable iff (reset)
        (file_wr && blocked) |=> !mem_wr_r;
    endproperty
    a_null_write: assert property (p_null_write) else $error("self write reached memory");

    property p_ind_addr;
        @(posedge clk) disable iff (reset)
        ((file_rd || file_wr) && is_ind && !self_ref)
            |=> (mem_addr_r == {$past(bank), $past(file_select_pointer)}) && (mem_rd_r || mem_wr_r);
    endproperty
    a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
endmodule : indirect_addr_unit

// ---- pc_stack_core.sv ----
// Program counter, page select, return stack and indirect addressing with AHB-Lite registers
//
// Notes on behaviour
// - Program counter is 13 bits; its low byte is software readable and writable.
// - Counter bits 12..8 are never readable; software writes them only through the high latch.
// - Any reset clears the counter, upper bits included.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Call and jump take 11 target bits plus latch bits 4..3 on top.
// - Return stack has eight 13-bit entries with a hidden pointer.
// - Calls and interrupt vectoring push the counter onto the stack.
// - A return pops the stack into all 13 counter bits.
// - Stack pushes and pops never alter the high latch.
// - Stack is circular; the ninth push overwrites the first entry.
// - No overflow or underflow indication; extra pushes and pops are silent.
// - Program space is 8K words split into 2K-word pages.
// - Naming the indirect port accesses the register the pointer selects.
// - Indirect read of the port with a null pointer returns 00h.
// - Indirect write of the port through itself stores nothing.
// - Indirect address is bank bit above the 8-bit pointer, nine bits.
`timescale 1ns/1ps
module pc_stack_core #(
    parameter logic [pcstack_pkg::PC_W-1:0] VECTOR_ADDR = 13'h0004
) (
    // Clock and reset
    input  wire logic                            CLK_SYS,
    input  wire logic                            RESET,
    // AHB-Lite slave
    input  wire logic                            HSEL,
    input  wire logic [pcstack_pkg::BUS_W-1:0]   HADDR,
    input  wire logic [1:0]                      HTRANS,
    input  wire logic                            HWRITE,
    input  wire logic [2:0]                      HSIZE,
    input  wire logic [pcstack_pkg::BUS_W-1:0]   HWDATA,
    input  wire logic                            HREADY,
    output logic      [pcstack_pkg::BUS_W-1:0]   HRDATA,
    output logic                                 HREADYOUT,
    output logic                                 HRESP,
    // Sequencer control
    input  wire logic                            FETCH_STEP,
    input  wire logic                            JUMP_REQ,
    input  wire logic                            CALL_REQ,
    input  wire logic                            RETURN_REQ,
    input  wire logic                            VECTOR_REQ,
    input  wire logic [pcstack_pkg::PAGE_W-1:0]  TARGET,
    output logic      [pcstack_pkg::PC_W-1:0]    PC_OUT,
    // Decoder file access
    input  wire logic [pcstack_pkg::DADDR_W-1:0] FILE_ADDR,
    input  wire logic                            FILE_RD,
    input  wire logic                            FILE_WR,
    input  wire logic [pcstack_pkg::DATA_W-1:0]  FILE_WDATA,
    output logic      [pcstack_pkg::DATA_W-1:0]  FILE_RDATA,
    output logic                                 FILE_RVALID,
    // Data memory
    output logic      [pcstack_pkg::DADDR_W-1:0] MEM_ADDR,
    output logic                                 MEM_RD,
    output logic                                 MEM_WR,
    output logic      [pcstack_pkg::DATA_W-1:0]  MEM_WDATA,
    input  wire logic [pcstack_pkg::DATA_W-1:0]  MEM_RDATA
);
    logic [pcstack_pkg::PC_W-1:0]    pc_r;
    logic [pcstack_pkg::PC_W-1:0]    pc_nxt;
    logic [pcstack_pkg::LATCH_W-1:0] latch_r;
    logic [pcstack_pkg::DATA_W-1:0]  fsr_r;
    logic                            bank_r;
    logic [1:0]                      page_sel;
    logic [pcstack_pkg::PC_W-1:0]    stack_top;
    logic                            push;
    logic                            pop;
    pcstack_pkg::flow_t              flow;

    // Bus state
    logic                            ahb_take;
    logic [pcstack_pkg::IDX_W-1:0]   take_idx;
    logic                            wr_pend_r;
    logic [pcstack_pkg::IDX_W-1:0]   wr_idx_r;
    logic                            pcl_wr;
    logic                            latch_wr;
    logic [pcstack_pkg::BUS_W-1:0]   rd_val;
    logic [pcstack_pkg::BUS_W-1:0]   hrdata_r;
    logic                            hreadyout_r;
    logic                            hresp_r;

    assign ahb_take = HSEL && HREADY && HTRANS[pcstack_pkg::TRANS_BIT];
    assign take_idx = pcstack_pkg::reg_index(HADDR);
    assign pcl_wr   = wr_pend_r && (wr_idx_r == pcstack_pkg::IDX_PC_LOW);
    assign latch_wr = wr_pend_r && (wr_idx_r == pcstack_pkg::IDX_PC_LATCH);
    assign page_sel = latch_r[pcstack_pkg::PAGE_SEL_HI:pcstack_pkg::PAGE_SEL_LO];

    // Vectoring beats a return, which beats a call, jump, low-byte write or step
    always_comb begin
        if (VECTOR_REQ) begin
            flow = pcstack_pkg::FLOW_VECTOR;
        end else if (RETURN_REQ) begin
            flow = pcstack_pkg::FLOW_RET;
        end else if (CALL_REQ) begin
            flow = pcstack_pkg::FLOW_CALL;
        end else if (JUMP_REQ) begin
            flow = pcstack_pkg::FLOW_JUMP;
        end else if (pcl_wr) begin
            flow = pcstack_pkg::FLOW_PCL;
        end else if (FETCH_STEP) begin
            flow = pcstack_pkg::FLOW_STEP;
        end else begin
            flow = pcstack_pkg::FLOW_HOLD;
        end
    end

    assign push = (flow == pcstack_pkg::FLOW_CALL) || (flow == pcstack_pkg::FLOW_VECTOR);
    assign pop  = (flow == pcstack_pkg::FLOW_RET);

    always_comb begin
        case (flow)
            pcstack_pkg::FLOW_STEP: begin
                pc_nxt = pc_r + pcstack_pkg::PC_ONE;
            end
            pcstack_pkg::FLOW_PCL: begin
                // Whole latch replaces the upper bits, so an add never carries
                pc_nxt = {latch_r, HWDATA[pcstack_pkg::LOW_W-1:0]};
            end
            pcstack_pkg::FLOW_JUMP, pcstack_pkg::FLOW_CALL: begin
                pc_nxt = {page_sel, TARGET};
            end
            pcstack_pkg::FLOW_RET: begin
                pc_nxt = stack_top;
            end
            pcstack_pkg::FLOW_VECTOR: begin
                pc_nxt = VECTOR_ADDR;
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pc_r <= pcstack_pkg::PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    return_stack_mem #(
        .DEPTH (pcstack_pkg::STACK_DEPTH),
        .WIDTH (pcstack_pkg::PC_W)
    ) u_stack (
        .clk   (CLK_SYS),
        .reset (RESET),
        .push  (push),
        .pop   (pop),
        .wdata (pc_r),
        .top_r (stack_top)
    );

    indirect_addr_unit u_ind (
        .clk           (CLK_SYS),
        .reset         (RESET),
        .file_select_pointer           (fsr_r),
        .bank          (bank_r),
        .file_addr     (FILE_ADDR),
        .file_rd       (FILE_RD),
        .file_wr       (FILE_WR),
        .file_wdata    (FILE_WDATA),
        .file_rdata_r  (FILE_RDATA),
        .file_rvalid_r (FILE_RVALID),
        .mem_addr_r    (MEM_ADDR),
        .mem_rd_r      (MEM_RD),
        .mem_wr_r      (MEM_WR),
        .mem_wdata_r   (MEM_WDATA),
        .mem_rdata     (MEM_RDATA)
    );

    // Address phase capture; writes land in the following data phase
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
        end else begin
            wr_pend_r <= ahb_take && HWRITE;
            wr_idx_r  <= take_idx;
        end
    end

    // Only a bus write to the latch changes it; stack traffic leaves it alone
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            latch_r <= pcstack_pkg::LATCH_RESET;
        end else if (latch_wr) begin
            latch_r <= HWDATA[pcstack_pkg::LATCH_W-1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            fsr_r  <= pcstack_pkg::DATA_ZERO;
            bank_r <= 1'b0;
        end else if (wr_pend_r) begin
            if (wr_idx_r == pcstack_pkg::IDX_FSR) begin
                fsr_r <= HWDATA[pcstack_pkg::DATA_W-1:0];
            end
            if (wr_idx_r == pcstack_pkg::IDX_STATUS) begin
                bank_r <= HWDATA[pcstack_pkg::BANK_BIT];
            end
        end
    end

    // Read data is sampled in the address phase, so a write just before is not yet seen
    always_comb begin
        rd_val = pcstack_pkg::BUS_ZERO;
        case (take_idx)
            pcstack_pkg::IDX_PC_LOW: begin
                rd_val[pcstack_pkg::LOW_W-1:0] = pc_r[pcstack_pkg::LOW_W-1:0];
            end
            pcstack_pkg::IDX_PC_LATCH: begin
                rd_val[pcstack_pkg::LATCH_W-1:0] = latch_r;
            end
            pcstack_pkg::IDX_FSR: begin
                rd_val[pcstack_pkg::DATA_W-1:0] = fsr_r;
            end
            pcstack_pkg::IDX_STATUS: begin
                rd_val[pcstack_pkg::BANK_BIT] = bank_r;
            end
            default: begin
                rd_val = pcstack_pkg::BUS_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            hrdata_r <= pcstack_pkg::BUS_ZERO;
        end else if (ahb_take && !HWRITE) begin
            hrdata_r <= rd_val;
        end
    end

    // Zero wait states and never an error
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= pcstack_pkg::HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= pcstack_pkg::HRESP_OKAY;
        end
    end

    assign HRDATA    = hrdata_r;
    assign HREADYOUT = hreadyout_r;
    assign HRESP     = hresp_r;
    assign PC_OUT    = pc_r;

    property p_reset_clear;
        @(posedge CLK_SYS)
        RESET |=> (pc_r == 13'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("pc not cleared by reset");

    property p_pcl_load;
        @(posedge CLK_SYS) disable iff (RESET)
        (flow == pcstack_pkg::FLOW_PCL)
            |=> (pc_r == {$past(latch_r), $past(HWDATA[7:0])});
    endproperty
    a_pcl_load: assert property (p_pcl_load) else $error("low byte write load wrong");

    property p_page_jump;
        @(posedge CLK_SYS) disable iff (RESET)
        (flow == pcstack_pkg::FLOW_JUMP) |=> (pc_r == {$past(page_sel), $past(TARGET)});
    endproperty
    a_page_jump: assert property (p_page_jump) else $error("jump target wrong");

    property p_call_push;
        @(posedge CLK_SYS) disable iff (RESET)
        (flow == pcstack_pkg::FLOW_CALL)
            |=> (stack_top == $past(pc_r)) && (pc_r[10:0] == $past(TARGET));
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push");

    property p_return_pop;
        @(posedge CLK_SYS) disable iff (RESET)
        (flow == pcstack_pkg::FLOW_CALL) ##1 (flow == pcstack_pkg::FLOW_RET)
            |=> (pc_r == $past(pc_r, 2));
    endproperty
    a_return_pop: assert property (p_return_pop) else $error("return address wrong");

    property p_latch_kept;
        @(posedge CLK_SYS) disable iff (RESET)
        ((push || pop) && !latch_wr) |=> (latch_r == $past(latch_r));
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("stack op changed latch");

    property p_step;
        @(posedge CLK_SYS) disable iff (RESET)
        (flow == pcstack_pkg::FLOW_STEP) |=> (pc_r == $past(pc_r) + 13'h0001);
    endproperty
    a_step: assert property (p_step) else $error("fetch step wrong");

    property p_pcl_read;
        @(posedge CLK_SYS) disable iff (RESET)
        (ahb_take && !HWRITE && take_idx == pcstack_pkg::IDX_PC_LOW)
            |=> (HRDATA == {24'h000000, $past(pc_r[7:0])});
    endproperty
    a_pcl_read: assert property (p_pcl_read) else $error("low byte read wrong");
endmodule : pc_stack_core

// ---- data_mem_model.sv ----
// Data-memory partner that answers indirect file accesses in the same cycle
`timescale 1ns/1ps
module data_mem_model (
    // Clock
    input  wire logic       clk,
    // Memory request
    input  wire logic [8:0] mem_addr,
    input  wire logic       mem_rd,
    input  wire logic       mem_wr,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata
);
    logic [7:0] mem [512];
    logic [7:0] last_r;
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
        last_r = 8'h00;
    end
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            last_r <= mem[mem_addr];
        end
    end
    // Outside a read the bus shows the inverse, so stale data never passes for a good answer
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
endmodule : data_mem_model

// ---- test_pc_stack_core.sv ----
// Self-checking bench for the program counter, return stack and indirect addressing
`timescale 1ns/1ps
module test_pc_stack_core;
    logic        clk_sys, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        fetch_step, jump_req, call_req, return_req, vector_req;
    logic [10:0] target;
    logic [12:0] pc_out;
    logic [8:0]  file_addr, mem_addr;
    logic        file_rd, file_wr, file_rvalid, mem_rd, mem_wr;
    logic [7:0]  file_wdata, file_rdata, mem_wdata, mem_rdata;
    int          failures, total_checks;

    assign hready = hreadyout;

    pc_stack_core uut (.CLK_SYS(clk_sys), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .FETCH_STEP(fetch_step),
        .JUMP_REQ(jump_req), .CALL_REQ(call_req), .RETURN_REQ(return_req),
        .VECTOR_REQ(vector_req), .TARGET(target), .PC_OUT(pc_out), .FILE_ADDR(file_addr),
        .FILE_RD(file_rd), .FILE_WR(file_wr), .FILE_WDATA(file_wdata),
        .FILE_RDATA(file_rdata), .FILE_RVALID(file_rvalid), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));

    data_mem_model mem_model (.clk(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Only the watchdog ends a wait for ready that never comes
    task automatic wait_rdy();
        do begin
            @(posedge clk_sys);
        end while (hready !== 1'b1);
    endtask : wait_rdy

    // Entered just after a rising edge; read data is taken at the closing edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask : ahb

    // Kind bits: vector, return, call, jump
    task automatic seq(input logic [3:0] kind, input logic [10:0] tgt);
        {vector_req, return_req, call_req, jump_req} <= kind;
        target <= tgt;
        @(posedge clk_sys);
        {vector_req, return_req, call_req, jump_req} <= 4'h0;
        @(posedge clk_sys);
    endtask : seq

    task automatic step();
        fetch_step <= 1'b1;
        @(posedge clk_sys);
        fetch_step <= 1'b0;
        @(posedge clk_sys);
    endtask : step

    task automatic facc(input logic wr, input logic [8:0] a, input logic [7:0] wd,
                        output logic m, output logic [8:0] ma, output logic [7:0] rd);
        file_addr  <= a;
        file_wr    <= wr;
        file_rd    <= !wr;
        file_wdata <= wd;
        @(posedge clk_sys);
        file_rd <= 1'b0;
        file_wr <= 1'b0;
        m  = 1'b0;
        ma = 9'h000;
        rd = 8'hxx;
        repeat (3) begin
            @(posedge clk_sys);
            if (mem_rd === 1'b1 || mem_wr === 1'b1) begin
                m  = 1'b1;
                ma = mem_addr;
            end
            if (file_rvalid === 1'b1) rd = file_rdata;
        end
    endtask : facc

    task automatic t_loads();
        logic [31:0] d;
        ahb(1'b1, 32'h04, 32'h1f, d);
        ahb(1'b1, 32'h00, 32'ha5, d);
        @(posedge clk_sys);
        chk("pc_out", 32'h1fa5, 32'(pc_out));
        ahb(1'b0, 32'h00, 32'h0, d);
        chk("pc_low_byte_reg", 32'ha5, d);
        ahb(1'b0, 32'h04, 32'h0, d);
        chk("pc_high_latch", 32'h1f, d);
        ahb(1'b0, 32'h40, 32'h0, d);
        chk("unmapped", 32'h0, d);
        seq(4'h1, 11'h123);
        chk("pc_out", 32'h1923, 32'(pc_out));
        step();
        chk("pc_out", 32'h1924, 32'(pc_out));
        ahb(1'b1, 32'h00, 32'hff, d);
        @(posedge clk_sys);
        chk("pc_out", 32'h1fff, 32'(pc_out));
        step();
        chk("pc_out", 32'h0, 32'(pc_out));
        seq(4'h1, 11'h7ff);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("pc_out", 32'h0, 32'(pc_out));
    endtask : t_loads

    task automatic t_stack();
        logic [31:0] d;
        ahb(1'b1, 32'h04, 32'h07, d);
        for (int i = 1; i <= 9; i++) begin
            seq(4'h2, 11'(i * 16 + 3));
        end
        for (int i = 8; i >= 0; i--) begin
            seq(4'h4, 11'h0);
            chk("pop", 32'((i == 0) ? 131 : i * 16 + 3), 32'(pc_out));
        end
        ahb(1'b0, 32'h04, 32'h0, d);
        chk("pc_high_latch", 32'h07, d);
        seq(4'h8, 11'h0);
        chk("pc_out", 32'h4, 32'(pc_out));
        seq(4'h4, 11'h0);
        chk("pc_out", 32'd131, 32'(pc_out));
        // Call immediately followed by a return
        call_req <= 1'b1;
        target   <= 11'h055;
        @(posedge clk_sys);
        call_req   <= 1'b0;
        return_req <= 1'b1;
        @(posedge clk_sys);
        return_req <= 1'b0;
        @(posedge clk_sys);
        chk("pc_out", 32'd131, 32'(pc_out));
    endtask : t_stack

    task automatic t_indirect();
        logic [31:0] d;
        logic        m;
        logic [8:0]  a;
        logic [7:0]  r;
        ahb(1'b1, 32'h0c, 32'h80, d);
        ahb(1'b1, 32'h08, 32'h35, d);
        facc(1'b0, 9'h000, 8'h00, m, a, r);
        chk("mem_addr", 32'h135, 32'(a));
        chk("file_rdata", 32'h6f, 32'(r));
        facc(1'b1, 9'h080, 8'h3c, m, a, r);
        facc(1'b0, 9'h000, 8'h00, m, a, r);
        chk("file_rdata", 32'h3c, 32'(r));
        facc(1'b0, 9'h135, 8'h00, m, a, r);
        chk("mem_addr", 32'h135, 32'(a));
        chk("file_rdata", 32'h3c, 32'(r));
        ahb(1'b1, 32'h08, 32'h00, d);
        facc(1'b0, 9'h000, 8'h00, m, a, r);
        chk("mem_access", 32'h0, 32'(m));
        chk("file_rdata", 32'h0, 32'(r));
        ahb(1'b1, 32'h08, 32'h80, d);
        facc(1'b1, 9'h000, 8'h77, m, a, r);
        chk("mem_access", 32'h0, 32'(m));
    endtask : t_indirect

    initial begin
        {reset, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 1'b1, 35'h0, 32'h0, 3'h2};
        {fetch_step, jump_req, call_req, return_req, vector_req, target} = 16'h0;
        {file_addr, file_rd, file_wr, file_wdata} = 19'h0;
        failures     = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("pc_out", 32'h0, 32'(pc_out));
        t_loads();
        t_stack();
        t_indirect();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
endmodule : test_pc_stack_core
